// [verilog/ibtq_regs.svh]
// Constants for the image block transfer queue
`ifndef IBTQ_REGS_SVH
`define IBTQ_REGS_SVH

// Transfer method codes on the method select port
`define IBTQ_METHOD_BASIC   2'h0
`define IBTQ_METHOD_AUTO    2'h1
`define IBTQ_METHOD_USER    2'h2

// Manual stream variant codes
`define IBTQ_VARIANT_CONT   1'h0
`define IBTQ_VARIANT_FIXED  1'h1

// Defaults
`define IBTQ_DEPTH_DEF      8
`define IBTQ_DESC_W_DEF     16
`define IBTQ_QUOTA_W_DEF    16
`define IBTQ_LOST_W_DEF     32
`define IBTQ_FILL_W_DEF     16
`define IBTQ_PKT_BYTES_DEF  1024

`endif

// [verilog/ibtq_pkg.sv]
// Types for the image block transfer queue
`default_nettype none

package ibtq_pkg;

    typedef enum logic [1:0] {
        IBTQ_ST_IDLE  = 2'b00,
        IBTQ_ST_FETCH = 2'b01,
        IBTQ_ST_SEND  = 2'b10
    } ibtq_state_t;

endpackage

`default_nettype wire

// [verilog/ibtq_desc_mem.sv]
// Descriptor memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module ibtq_desc_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_rst_n,
    // Write side
    input  wire logic          i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [W-1:0]  i_wr_data,
    // Read side
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [W-1:0]  o_rd_data
);

    logic [W-1:0] mem [DEPTH];

    // Read before write on a shared address returns the old word
    always_ff @(posedge i_core_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule

`default_nettype wire

// [verilog/ibtq_core.sv]
// Image block transfer queue between processing path and stream link
//
// How it works
// - A block is queued as one descriptor, covering image plus appended metadata.
// - Software picks basic, automatic or user-controlled transfer method.
// - Automatic methods start the newest block once one packet of data exists.
// - Next block launches in the same cycle the link reports completion.
// - Blocks wait in the queue while the link is slower than production.
// - Queue capacity is shown as a constant read-only value.
// - Occupancy output counts blocks held and not yet started.
// - Blocks leave strictly oldest first.
// - Push into a full queue overwrites the oldest unstarted block.
// - Each overwrite increments the lost block counter.
// - A block in flight completes before the next one starts.
// - User-controlled method offers continuous or fixed-count variant.
// - Continuous variant streams like automatic, gated by go and halt.
// - Fixed-count variant sends exactly the quota then stops.
// - Acquisition start or stop never touches queue or transfer state.
// - Channel close empties the queue and cancels pending transmission.
// - Halt lets the block in progress finish.
// - Go and halt act only in the user-controlled method.
// - Quota is used only in the fixed-count variant.
`timescale 1ns/1ps
`default_nettype none
`include "ibtq_regs.svh"

module ibtq_core #(
    parameter int DEPTH     = `IBTQ_DEPTH_DEF,
    parameter int DESC_W    = `IBTQ_DESC_W_DEF,
    parameter int QUOTA_W   = `IBTQ_QUOTA_W_DEF,
    parameter int LOST_W    = `IBTQ_LOST_W_DEF,
    parameter int FILL_W    = `IBTQ_FILL_W_DEF,
    parameter int PKT_BYTES = `IBTQ_PKT_BYTES_DEF,
    parameter int AW        = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_n,
    // Software control
    input  wire logic [1:0]         i_xfer_method_select,
    input  wire logic               i_manual_stream_variant,
    input  wire logic [QUOTA_W-1:0] i_fixed_block_quota,
    input  wire logic               i_stream_go_cmd,
    input  wire logic               i_stream_halt_cmd,
    input  wire logic               i_chan_close,
    // Blocks from processing path
    input  wire logic               i_blk_push,
    input  wire logic [DESC_W-1:0]  i_blk_desc,
    input  wire logic               i_blk_end,
    input  wire logic [FILL_W-1:0]  i_blk_fill_bytes,
    // Link layer transmitter
    output logic                    o_tx_start,
    output logic      [DESC_W-1:0]  o_tx_desc,
    output logic                    o_tx_busy,
    output logic                    o_tx_abort,
    input  wire logic               i_tx_done,
    // Status readouts
    output logic      [AW:0]        o_queue_capacity_readout,
    output logic      [AW:0]        o_queue_occupancy_readout,
    output logic      [LOST_W-1:0]  o_lost_block_counter,
    output logic                    o_stream_enabled,
    output logic      [QUOTA_W-1:0] o_blocks_left
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    localparam logic [AW:0]     CAP     = (AW+1)'(DEPTH);
    localparam logic [AW-1:0]   LAST    = AW'(DEPTH - 1);
    localparam logic [FILL_W-1:0] PKT   = FILL_W'(PKT_BYTES);

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST) ? '0 : p + 1'b1;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic [AW-1:0]        wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0]        rd_ptr_r, rd_ptr_nxt;
    logic [AW:0]          cnt_r, cnt_nxt;
    logic                 tail_open_r, tail_open_nxt;
    logic [LOST_W-1:0]    lost_r, lost_nxt;
    logic                 run_r, run_nxt;
    logic [QUOTA_W-1:0]   left_r, left_nxt;
    ibtq_pkg::ibtq_state_t st_r, st_nxt;
    logic                 start_r, start_nxt;
    logic                 abort_r, abort_nxt;
    logic [DESC_W-1:0]    desc_r, desc_nxt;
    logic [DESC_W-1:0]    mem_rdata;

    logic user_m;
    logic fixed_m;
    logic go;
    logic halt;
    logic enabled;
    logic head_ready;
    logic slot_free;
    logic launch;
    logic push;
    logic overflow;

    // ****************************************************************
    // Command and launch decode
    // ****************************************************************
    always_comb begin
        user_m  = (i_xfer_method_select == `IBTQ_METHOD_USER);
        fixed_m = user_m && (i_manual_stream_variant == `IBTQ_VARIANT_FIXED);
        // Commands outside the user method are dropped, never deferred
        go      = i_stream_go_cmd && user_m;
        halt    = i_stream_halt_cmd && user_m;
        // Automatic methods always stream; user method follows go and halt
        enabled = user_m ? run_r : 1'b1;
        // Only the newest block may still be filling; wait for one packet
        head_ready = (cnt_r != '0)
                     && ((cnt_r > (AW+1)'(1)) || !tail_open_r
                         || (i_blk_fill_bytes >= PKT));
        // Transmitter free now, or freeing this very cycle
        slot_free = (st_r == ibtq_pkg::IBTQ_ST_IDLE)
                    || ((st_r == ibtq_pkg::IBTQ_ST_SEND) && i_tx_done);
        launch  = slot_free && enabled && head_ready && !i_chan_close;
        push    = i_blk_push && !i_chan_close;
        // A popped head has begun, so it is never the one overwritten
        overflow = push && (cnt_r == CAP) && !launch;
    end

    // ****************************************************************
    // Queue control
    // ****************************************************************
    always_comb begin
        wr_ptr_nxt    = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
        rd_ptr_nxt    = (launch || overflow) ? ptr_inc(rd_ptr_r) : rd_ptr_r;
        cnt_nxt       = cnt_r;
        if (push && !launch && !overflow) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (launch && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        lost_nxt      = overflow ? lost_r + 1'b1 : lost_r;
        // An end beside a push closes the older block; the new one is open
        tail_open_nxt = push ? 1'b1 : (i_blk_end ? 1'b0 : tail_open_r);

        // Acquisition has no path into any of this state
        if (i_chan_close) begin
            wr_ptr_nxt    = '0;
            rd_ptr_nxt    = '0;
            cnt_nxt       = '0;
            tail_open_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            lost_r      <= '0;
            tail_open_r <= 1'b0;
        end else begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            cnt_r       <= cnt_nxt;
            lost_r      <= lost_nxt;
            tail_open_r <= tail_open_nxt;
        end
    end

    // ****************************************************************
    // Stream gating
    // ****************************************************************
    always_comb begin
        run_nxt  = run_r;
        left_nxt = left_r;

        // Quota counts launches; a block cut by close still used its turn
        if (go) begin
            run_nxt = 1'b1;
            if (fixed_m) begin
                left_nxt = i_fixed_block_quota;
                run_nxt  = (i_fixed_block_quota != '0);
            end
        end else if (launch && fixed_m) begin
            left_nxt = left_r - 1'b1;
            if (left_r == QUOTA_W'(1)) begin
                run_nxt = 1'b0;
            end
        end
        // Halt only stops new launches; the block in flight runs on
        if (halt) begin
            run_nxt = 1'b0;
        end
        // In the user method a reopened channel must see a fresh go before streaming again
        if (i_chan_close) begin
            run_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            run_r  <= 1'b0;
            left_r <= '0;
        end else begin
            run_r  <= run_nxt;
            left_r <= left_nxt;
        end
    end

    // ****************************************************************
    // Transmit sequencing
    // ****************************************************************
    always_comb begin
        st_nxt    = st_r;
        start_nxt = 1'b0;
        abort_nxt = 1'b0;
        desc_nxt  = desc_r;

        case (st_r)
            ibtq_pkg::IBTQ_ST_IDLE: begin
                if (launch) begin
                    st_nxt = ibtq_pkg::IBTQ_ST_FETCH;
                end
            end
            // One dead cycle lets the registered memory present the head
            ibtq_pkg::IBTQ_ST_FETCH: begin
                desc_nxt  = mem_rdata;
                start_nxt = 1'b1;
                st_nxt    = ibtq_pkg::IBTQ_ST_SEND;
            end
            ibtq_pkg::IBTQ_ST_SEND: begin
                if (i_tx_done) begin
                    st_nxt = launch ? ibtq_pkg::IBTQ_ST_FETCH
                                    : ibtq_pkg::IBTQ_ST_IDLE;
                end
            end
            default: begin
                st_nxt = ibtq_pkg::IBTQ_ST_IDLE;
            end
        endcase

        if (i_chan_close) begin
            abort_nxt = (st_r != ibtq_pkg::IBTQ_ST_IDLE);
            st_nxt    = ibtq_pkg::IBTQ_ST_IDLE;
            start_nxt = 1'b0;
            // Descriptor only moves together with a start pulse
            desc_nxt  = desc_r;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r    <= ibtq_pkg::IBTQ_ST_IDLE;
            start_r <= 1'b0;
            abort_r <= 1'b0;
            desc_r  <= '0;
        end else begin
            st_r    <= st_nxt;
            start_r <= start_nxt;
            abort_r <= abort_nxt;
            desc_r  <= desc_nxt;
        end
    end

    // ****************************************************************
    // Descriptor store
    // ****************************************************************
    // Read address is the head; data is valid in the FETCH cycle
    ibtq_desc_mem #(
        .W     (DESC_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr_en    (push),
        .i_wr_addr  (wr_ptr_r),
        .i_wr_data  (i_blk_desc),
        .i_rd_addr  (rd_ptr_r),
        .o_rd_data  (mem_rdata)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_tx_start                = start_r;
    assign o_tx_desc                 = desc_r;
    assign o_tx_busy                 = (st_r == ibtq_pkg::IBTQ_ST_SEND);
    assign o_tx_abort                = abort_r;

    // ****************************************************************
    // Status readouts
    // ****************************************************************
    // Capacity is fixed at build time and never moves
    assign o_queue_capacity_readout  = CAP;
    assign o_queue_occupancy_readout = cnt_r;
    assign o_lost_block_counter      = lost_r;
    assign o_stream_enabled          = enabled;
    assign o_blocks_left             = left_r;

endmodule

`default_nettype wire

// [dv/ibtq_core_assertions.sv]
// Port checker for the image block transfer queue
`timescale 1ns/1ps
`default_nettype none

module ibtq_core_checker #(
    parameter int DEPTH  = 8,
    parameter int DESC_W = 16,
    parameter int LOST_W = 32,
    parameter int AW     = 3
) (
    input wire logic              i_core_clk,
    input wire logic              i_rst_n,
    input wire logic [1:0]        i_xfer_method_select,
    input wire logic              i_stream_halt_cmd,
    input wire logic              i_chan_close,
    input wire logic              i_blk_push,
    input wire logic              o_tx_start,
    input wire logic [DESC_W-1:0] o_tx_desc,
    input wire logic              o_tx_busy,
    input wire logic              o_tx_abort,
    input wire logic [AW:0]       o_queue_capacity_readout,
    input wire logic [AW:0]       o_queue_occupancy_readout,
    input wire logic [LOST_W-1:0] o_lost_block_counter,
    input wire logic              o_stream_enabled
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_cap_const: assert property (o_queue_capacity_readout == DEPTH)
        else $error("capacity readout wrong");
    a_occ_bound: assert property (o_queue_occupancy_readout <= DEPTH)
        else $error("occupancy above depth");
    a_lost_full: assert property ((o_lost_block_counter != $past(o_lost_block_counter)) |->
        ($past(o_queue_occupancy_readout) == DEPTH) && $past(i_blk_push))
        else $error("loss without full push");
    a_start_fresh: assert property (o_tx_start |-> o_tx_busy && !$past(o_tx_busy))
        else $error("start while in flight");
    a_abort_cause: assert property (o_tx_abort |-> $past(i_chan_close))
        else $error("abort without close");
    a_close_flush: assert property (i_chan_close |=>
        (o_queue_occupancy_readout == '0) && !o_tx_busy)
        else $error("close left queue or transfer");
    a_auto_enabled: assert property ((i_xfer_method_select != 2'h2) |-> o_stream_enabled)
        else $error("auto method not streaming");
    a_halt_stops: assert property ((i_xfer_method_select == 2'h2) && i_stream_halt_cmd
        |=> !o_stream_enabled)
        else $error("halt ignored");
    a_desc_steady: assert property (!o_tx_start |-> $stable(o_tx_desc))
        else $error("descriptor moved");

    c_abort: cover property (o_tx_abort);
    c_loss: cover property (o_lost_block_counter != $past(o_lost_block_counter));
    c_halt: cover property ((i_xfer_method_select == 2'h2) && i_stream_halt_cmd && o_tx_busy);
endmodule

bind ibtq_core ibtq_core_checker #(
    .DEPTH  (DEPTH),
    .DESC_W (DESC_W),
    .LOST_W (LOST_W),
    .AW     (AW)
) u_chk (
    .i_core_clk                (i_core_clk),
    .i_rst_n                   (i_rst_n),
    .i_xfer_method_select      (i_xfer_method_select),
    .i_stream_halt_cmd         (i_stream_halt_cmd),
    .i_chan_close              (i_chan_close),
    .i_blk_push                (i_blk_push),
    .o_tx_start                (o_tx_start),
    .o_tx_desc                 (o_tx_desc),
    .o_tx_busy                 (o_tx_busy),
    .o_tx_abort                (o_tx_abort),
    .o_queue_capacity_readout  (o_queue_capacity_readout),
    .o_queue_occupancy_readout (o_queue_occupancy_readout),
    .o_lost_block_counter      (o_lost_block_counter),
    .o_stream_enabled          (o_stream_enabled)
);
`default_nettype wire

// [dv/ibtq_link_model.sv]
// Link layer transmitter model answering each block not aborted with a done pulse
`timescale 1ns/1ps
`default_nettype none

module ibtq_link_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tx_start,
    input  wire logic       i_tx_abort,
    input  wire logic [7:0] i_lat,
    output logic            o_tx_done
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       act_r;
    logic       act_nxt;

    // Done only for a block it holds; an aborted block never answers
    assign o_tx_done = act_r && (cnt_r == 8'h00);

    always_comb begin
        act_nxt = act_r && (cnt_r != 8'h00);
        cnt_nxt = cnt_r - 8'h01;
        if (i_tx_start) begin
            act_nxt = 1'b1;
            cnt_nxt = i_lat;
        end
        if (!i_rst_n || i_tx_abort) begin
            act_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        act_r <= act_nxt;
        cnt_r <= cnt_nxt;
    end
endmodule
`default_nettype wire

// [dv/ibtq_core_tb.sv]
// Self-checking bench for the image block transfer queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); end end

module ibtq_core_tb;
    logic        i_core_clk, i_rst_n, i_manual_stream_variant, i_stream_go_cmd;
    logic        i_stream_halt_cmd, i_chan_close, i_blk_push, i_blk_end, i_tx_done;
    logic        o_tx_start, o_tx_busy, o_tx_abort, o_stream_enabled;
    logic [1:0]  i_xfer_method_select;
    logic [15:0] i_fixed_block_quota, i_blk_desc, i_blk_fill_bytes, o_tx_desc, o_blocks_left;
    logic [2:0]  o_queue_capacity_readout, o_queue_occupancy_readout;
    logic [31:0] o_lost_block_counter;
    logic [7:0]  lat;
    logic [15:0] sent[$];
    int          n_mismatch, check_count, n_abort, i;
    int          ov[5] = '{0, 3, 4, 5, 6};

    ibtq_core #(
        .DEPTH (4)
    ) DUT (
        .i_core_clk                (i_core_clk),
        .i_rst_n                   (i_rst_n),
        .i_xfer_method_select      (i_xfer_method_select),
        .i_manual_stream_variant   (i_manual_stream_variant),
        .i_fixed_block_quota       (i_fixed_block_quota),
        .i_stream_go_cmd           (i_stream_go_cmd),
        .i_stream_halt_cmd         (i_stream_halt_cmd),
        .i_chan_close              (i_chan_close),
        .i_blk_push                (i_blk_push),
        .i_blk_desc                (i_blk_desc),
        .i_blk_end                 (i_blk_end),
        .i_blk_fill_bytes          (i_blk_fill_bytes),
        .o_tx_start                (o_tx_start),
        .o_tx_desc                 (o_tx_desc),
        .o_tx_busy                 (o_tx_busy),
        .o_tx_abort                (o_tx_abort),
        .i_tx_done                 (i_tx_done),
        .o_queue_capacity_readout  (o_queue_capacity_readout),
        .o_queue_occupancy_readout (o_queue_occupancy_readout),
        .o_lost_block_counter      (o_lost_block_counter),
        .o_stream_enabled          (o_stream_enabled),
        .o_blocks_left             (o_blocks_left)
    );
    ibtq_link_model u_link (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_tx_start (o_tx_start),
        .i_tx_abort (o_tx_abort),
        .i_lat      (lat),
        .o_tx_done  (i_tx_done)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    // Sampled mid-cycle, well away from the edge that moves the pulses
    always @(negedge i_core_clk) begin
        if (o_tx_start === 1'b1) sent.push_back(o_tx_desc);
        if (o_tx_abort === 1'b1) n_abort++;
    end

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // k: 0 push, 1 go, 2 halt, 3 close, 4 block end
    task automatic pulse(input int k, input logic [15:0] d);
        @(negedge i_core_clk);
        i_blk_desc = d;
        {i_blk_end, i_chan_close, i_stream_halt_cmd, i_stream_go_cmd, i_blk_push} = 5'h01 << k;
        @(negedge i_core_clk);
        {i_blk_end, i_chan_close, i_stream_halt_cmd, i_stream_go_cmd, i_blk_push} = 5'h00;
    endtask

    // Bounded so a stuck transmitter cannot hang the run
    task automatic wait_sent(input int n);
        int j;
        for (j = 0; j < 3000 && sent.size() < n; j++) @(negedge i_core_clk);
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #80000;
        n_mismatch++;
        final_report();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        {i_blk_end, i_chan_close, i_stream_halt_cmd, i_stream_go_cmd, i_blk_push} = 5'h00;
        i_rst_n = 1'b0;
        i_xfer_method_select = 2'h0;
        i_manual_stream_variant = 1'b0;
        i_fixed_block_quota = 16'h0000;
        i_blk_desc = 16'h0000;
        i_blk_fill_bytes = 16'h0400;
        lat = 8'h14;
        cyc(2);
        i_rst_n = 1'b1;
        cyc(1);
        `CHK("capacity", 3'h4, o_queue_capacity_readout)
        `CHK("occupancy", 3'h0, o_queue_occupancy_readout)
        `CHK("lost", 32'h0, o_lost_block_counter)
        // Basic method, slow link: queue builds, oldest leaves first
        for (i = 0; i < 3; i++) pulse(0, 16'h00A0 + i);
        cyc(2);
        `CHK("occ_build", 3'h2, o_queue_occupancy_readout)
        wait_sent(3);
        for (i = 0; i < 3; i++) `CHK("order", 16'h00A0 + i, sent[i])
        // Automatic: held until a packet's worth or block end
        cyc(30);
        sent.delete();
        i_xfer_method_select = 2'h1;
        i_blk_fill_bytes = 16'h0000;
        pulse(0, 16'h00B0);
        cyc(8);
        `CHK("held", 0, sent.size())
        pulse(4, 16'h0000);
        wait_sent(1);
        `CHK("released", 16'h00B0, sent[0])
        // Overflow replaces oldest unstarted; halt has no effect here
        cyc(30);
        sent.delete();
        i_blk_fill_bytes = 16'h0400;
        lat = 8'h50;
        for (i = 0; i < 7; i++) pulse(0, 16'h00C0 + i);
        pulse(2, 16'h0000);
        `CHK("lost_cnt", 32'h2, o_lost_block_counter)
        `CHK("occ_full", 3'h4, o_queue_occupancy_readout)
        wait_sent(5);
        for (i = 0; i < 5; i++) `CHK("ovf_order", 16'h00C0 + ov[i], sent[i])
        // Close in mid-block flushes and aborts
        cyc(90);
        sent.delete();
        for (i = 0; i < 3; i++) pulse(0, 16'h00D0 + i);
        pulse(3, 16'h0000);
        `CHK("occ_close", 3'h0, o_queue_occupancy_readout)
        cyc(200);
        `CHK("aborts", 1, n_abort)
        `CHK("no_more", 1, sent.size())
        // User continuous: gated by go and halt, quota ignored
        sent.delete();
        lat = 8'h0A;
        i_xfer_method_select = 2'h2;
        i_fixed_block_quota = 16'h0001;
        for (i = 0; i < 4; i++) pulse(0, 16'h00E0 + i);
        cyc(10);
        `CHK("gated", 0, sent.size())
        `CHK("enabled", 1'b0, o_stream_enabled)
        pulse(1, 16'h0000);
        wait_sent(2);
        pulse(2, 16'h0000);
        cyc(40);
        `CHK("halted", 2, sent.size())
        `CHK("finished", 1'b0, o_tx_busy)
        `CHK("occ_held", 3'h2, o_queue_occupancy_readout)
        pulse(3, 16'h0000);
        // Fixed count: quota loaded before go
        sent.delete();
        i_manual_stream_variant = 1'b1;
        i_fixed_block_quota = 16'h0002;
        for (i = 0; i < 3; i++) pulse(0, 16'h00F0 + i);
        pulse(1, 16'h0000);
        cyc(100);
        `CHK("quota_sent", 2, sent.size())
        `CHK("quota_order", 16'h00F1, sent[1])
        `CHK("occ_left", 3'h1, o_queue_occupancy_readout)
        `CHK("blocks_left", 16'h0000, o_blocks_left)
        final_report();
    end
endmodule
`default_nettype wire
